//--- ipag_pkg.sv
// Package for the indirect pointer address generator: types and constants
`default_nettype none
package ipag_pkg;
	localparam int ADDR_W = 23;
	localparam int WORD_W = 16;
	localparam int NUM_PTR = 8;
	localparam logic [ADDR_W-1:0] STEP_SHORT = 23'h000001;
	localparam logic [ADDR_W-1:0] STEP_LONG = 23'h000002;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 23'h000000;
	// Pointer configuration status: bit n selects circular for pointer n
	localparam int CIRC_BIT_BASE = 0;

	typedef enum logic [4:0] {
		IPAG_OP_PLAIN,
		IPAG_OP_REG_OFS,
		IPAG_OP_TMP2_OFS,
		IPAG_OP_LONG_OFS,
		IPAG_OP_SHORT_OFS,
		IPAG_OP_POST_INC,
		IPAG_OP_POST_DEC,
		IPAG_OP_POST_ADD_REG,
		IPAG_OP_POST_SUB_REG,
		IPAG_OP_POST_ADD_REV,
		IPAG_OP_POST_SUB_REV,
		IPAG_OP_POST_ADD_TMP2,
		IPAG_OP_POST_SUB_TMP2,
		IPAG_OP_PRE_INC,
		IPAG_OP_PRE_DEC,
		IPAG_OP_PRE_ADD_LONG
	} ipag_op_type;

	typedef enum logic [2:0] {
		IPAG_ACC_SINGLE,
		IPAG_ACC_LONG,
		IPAG_ACC_FIRST_DUAL,
		IPAG_ACC_SECOND_DUAL,
		IPAG_ACC_MMR,
		IPAG_ACC_REG_BIT,
		IPAG_ACC_IO
	} ipag_acc_type;

	// One operand request from the decoder
	typedef struct packed {
		logic                valid;
		ipag_op_type         op;
		ipag_acc_type        acc;
		logic [2:0]          ptr_sel;
		logic [WORD_W-1:0]   long_offset_const;
		logic [2:0]          short_offset_const;
	} ipag_req_type;

	// One generated address and pointer write-back
	typedef struct packed {
		logic                valid;
		logic                illegal;
		logic [ADDR_W-1:0]   addr;
		logic                ptr_we;
		logic [2:0]          ptr_sel;
		logic [ADDR_W-1:0]   ptr_new;
	} ipag_res_type;
endpackage : ipag_pkg
`default_nettype wire

//--- ipag_core.sv
// Indirect pointer address generator: single and dual-pointer operands
// Notes on behaviour
// - Short offset: zero-extend, add, pointer unchanged
// - Control mode accepts its listed operand set
// - DSP mode accepts its listed operand set
// - Dual mode: two 23-bit addresses, any pointer
// - Linear or circular chosen per pointer
// - Two-access instruction uses first/second dual
// - Parallel pair maps to first/second dual
// - Dual operand set independent of mode bit
// - Circular start added only when circular
// - All pointer arithmetic is 23 bits wide
// - Post-increment by one or two
// - Post-decrement by one or two
// - Post-add temp or zero pointer
// - Post-subtract temp or zero pointer
// - Register offset: temp or zero pointer
// - Second temp sign-extended, post add/sub
// - Dual operands only data-memory access types
`default_nettype none
module ipag_core
	import ipag_pkg::*;
(
	input  wire logic                       sys_clk,          // CPU clock
	input  wire logic                       rst_b,            // Sync reset
	input  wire logic                       dual_mode,        // Two-operand op
	input  wire ipag_req_type               req_x,            // First operand
	input  wire ipag_req_type               req_y,            // Second operand
	input  wire logic [NUM_PTR-1:0][ADDR_W-1:0] extended_auxiliary_pointer, // Pointers
	input  wire logic [WORD_W-1:0]          first_temp_register,  // Temp 0
	input  wire logic [WORD_W-1:0]          second_temp_register, // Temp 1
	input  wire logic                       control_mode_select,  // Mode bit
	input  wire logic                       legacy_compat_bit,    // Compat
	input  wire logic [WORD_W-1:0]          pointer_config_status, // Circ bits
	input  wire logic [3:0][WORD_W-1:0]     circular_start,   // Per pair
	output var  ipag_res_type               res_x,            // First result
	output var  ipag_res_type               res_y             // Second result
);

	typedef struct packed {
		ipag_res_type x;
		ipag_res_type y;
	} ipag_state_type;

	ipag_state_type state_q;
	ipag_state_type state_d;

	function automatic logic [ADDR_W-1:0] sext(input logic [WORD_W-1:0] v);
		sext = {{(ADDR_W-WORD_W){v[WORD_W-1]}}, v};
	endfunction : sext

	function automatic logic [ADDR_W-1:0] bitrev_add(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] b,
		input logic              sub
	);
		logic [ADDR_W-1:0] ra;
		logic [ADDR_W-1:0] rb;
		logic [ADDR_W-1:0] rs;
		for (int i = 0; i < ADDR_W; i++) begin
			ra[i] = a[ADDR_W-1-i];
			rb[i] = b[ADDR_W-1-i];
		end
		rs = sub ? ra - rb : ra + rb;
		for (int i = 0; i < ADDR_W; i++) begin
			bitrev_add[i] = rs[ADDR_W-1-i];
		end
	endfunction : bitrev_add

	// Operand legality against mode and dual restrictions
	function automatic logic op_legal(
		input ipag_op_type op,
		input logic        ctrl,
		input logic        dual
	);
		logic ok;
		ok = 1'b0;
		case (op)
			IPAG_OP_PLAIN, IPAG_OP_REG_OFS, IPAG_OP_POST_INC,
			IPAG_OP_POST_DEC, IPAG_OP_POST_ADD_REG,
			IPAG_OP_POST_SUB_REG, IPAG_OP_POST_ADD_TMP2,
			IPAG_OP_POST_SUB_TMP2: begin
				ok = 1'b1;
			end
			IPAG_OP_POST_ADD_REV, IPAG_OP_POST_SUB_REV,
			IPAG_OP_LONG_OFS, IPAG_OP_PRE_ADD_LONG: begin
				ok = !dual;
			end
			IPAG_OP_SHORT_OFS: begin
				ok = ctrl && !dual;
			end
			IPAG_OP_TMP2_OFS, IPAG_OP_PRE_INC, IPAG_OP_PRE_DEC: begin
				ok = !ctrl && !dual;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		op_legal = ok;
	endfunction : op_legal

	function automatic ipag_res_type gen(
		input ipag_req_type                      r,
		input logic                              dual,
		input logic [NUM_PTR-1:0][ADDR_W-1:0]    ptrs,
		input logic [WORD_W-1:0]                 tmp1,
		input logic [WORD_W-1:0]                 tmp2,
		input logic                              ctrl,
		input logic                              compat,
		input logic [WORD_W-1:0]                 cfg,
		input logic [3:0][WORD_W-1:0]            bsa
	);
		ipag_res_type      o;
		logic [ADDR_W-1:0] p;
		logic [ADDR_W-1:0] step;
		logic [ADDR_W-1:0] ofs0;
		logic [ADDR_W-1:0] ea;
		logic [ADDR_W-1:0] base;
		logic              acc_ok;
		o = '0;
		p = ptrs[r.ptr_sel];
		step = (r.acc == IPAG_ACC_LONG) ? STEP_LONG : STEP_SHORT;
		ofs0 = compat ? ptrs[0] : sext(tmp1);
		ea = p;
		o.ptr_new = p;
		o.ptr_we = 1'b0;
		case (r.op)
			IPAG_OP_PLAIN: ea = p;
			IPAG_OP_REG_OFS: ea = p + ofs0;
			IPAG_OP_TMP2_OFS: ea = p + sext(tmp2);
			IPAG_OP_LONG_OFS: ea = p + sext(r.long_offset_const);
			IPAG_OP_SHORT_OFS: ea = p + {20'h00000, r.short_offset_const};
			IPAG_OP_POST_INC: begin
				o.ptr_new = p + step;
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_DEC: begin
				o.ptr_new = p - step;
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_ADD_REG: begin
				o.ptr_new = p + ofs0;
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_SUB_REG: begin
				o.ptr_new = p - ofs0;
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_ADD_REV: begin
				o.ptr_new = bitrev_add(p, ofs0, 1'b0);
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_SUB_REV: begin
				o.ptr_new = bitrev_add(p, ofs0, 1'b1);
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_ADD_TMP2: begin
				o.ptr_new = p + sext(tmp2);
				o.ptr_we = 1'b1;
			end
			IPAG_OP_POST_SUB_TMP2: begin
				o.ptr_new = p - sext(tmp2);
				o.ptr_we = 1'b1;
			end
			IPAG_OP_PRE_INC: begin
				ea = p + step;
				o.ptr_new = ea;
				o.ptr_we = 1'b1;
			end
			IPAG_OP_PRE_DEC: begin
				ea = p - step;
				o.ptr_new = ea;
				o.ptr_we = 1'b1;
			end
			IPAG_OP_PRE_ADD_LONG: begin
				ea = p + sext(r.long_offset_const);
				o.ptr_new = ea;
				o.ptr_we = 1'b1;
			end
			default: ea = p;
		endcase
		// Circular start of the pointer's pair, else linear
		base = cfg[CIRC_BIT_BASE + int'(r.ptr_sel)] ?
			{7'h00, bsa[r.ptr_sel[2:1]]} : ADDR_RESET;
		// Full-width sum lets addresses cross main pages
		o.addr = ea + base;
		acc_ok = !dual || (r.acc == IPAG_ACC_SINGLE) ||
			(r.acc == IPAG_ACC_LONG) || (r.acc == IPAG_ACC_FIRST_DUAL) ||
			(r.acc == IPAG_ACC_SECOND_DUAL);
		o.illegal = r.valid && !(acc_ok && op_legal(r.op, ctrl, dual));
		o.valid = r.valid && !o.illegal;
		o.ptr_we = o.ptr_we && o.valid;
		o.ptr_sel = r.ptr_sel;
		gen = o;
	endfunction : gen

	always_comb begin
		state_d = state_q;
		// First request is the first dual operand, second the second
		state_d.x = gen(req_x, dual_mode, extended_auxiliary_pointer,
			first_temp_register, second_temp_register,
			control_mode_select, legacy_compat_bit,
			pointer_config_status, circular_start);
		state_d.y = gen(req_y, dual_mode, extended_auxiliary_pointer,
			first_temp_register, second_temp_register,
			control_mode_select, legacy_compat_bit,
			pointer_config_status, circular_start);
		if (!dual_mode) begin
			state_d.y = '0;
		end
		// Two writes to one pointer cannot both land; the second operand's write is dropped
		if (state_d.x.ptr_we && state_d.y.ptr_we &&
			state_d.x.ptr_sel == state_d.y.ptr_sel) begin
			state_d.y.ptr_we = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign res_x = state_q.x;
	assign res_y = state_q.y;

	sequence s_post_inc_req;
		req_x.valid && req_x.op == IPAG_OP_POST_INC &&
		req_x.acc == IPAG_ACC_SINGLE && !dual_mode;
	endsequence

	AST_POST_INC: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_post_inc_req |=> res_x.ptr_new == res_x.addr + 23'h000001 ||
			pointer_config_status[$past(req_x.ptr_sel)])
		else $error("post increment step wrong");

	AST_POST_DEC_LONG: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(req_x.valid && req_x.op == IPAG_OP_POST_DEC &&
		req_x.acc == IPAG_ACC_LONG && !dual_mode) |=>
		res_x.ptr_new == $past(extended_auxiliary_pointer[req_x.ptr_sel]) - 23'h000002)
		else $error("post decrement long step wrong");

	AST_SHORT_OFS: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(req_x.valid && req_x.op == IPAG_OP_SHORT_OFS && control_mode_select &&
		!dual_mode && req_x.acc == IPAG_ACC_SINGLE &&
		!pointer_config_status[req_x.ptr_sel]) |=>
		!res_x.ptr_we && res_x.addr ==
		$past(extended_auxiliary_pointer[req_x.ptr_sel]) +
		{20'h00000, $past(req_x.short_offset_const)})
		else $error("short offset address wrong");

	AST_REG_OFS: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(req_x.valid && req_x.op == IPAG_OP_REG_OFS && legacy_compat_bit &&
		!dual_mode && !pointer_config_status[req_x.ptr_sel]) |=>
		res_x.addr == $past(extended_auxiliary_pointer[req_x.ptr_sel]) +
		$past(extended_auxiliary_pointer[0]))
		else $error("register offset address wrong");

	AST_DUAL_ACC: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(dual_mode && req_y.valid && req_y.acc inside {IPAG_ACC_MMR,
		IPAG_ACC_REG_BIT, IPAG_ACC_IO}) |=>
		res_y.illegal && !res_y.valid)
		else $error("dual non-data access not refused");

	AST_DUAL_LONG: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(dual_mode && req_x.valid && req_x.op == IPAG_OP_LONG_OFS) |=>
		res_x.illegal)
		else $error("dual long offset not refused");

	AST_CTRL_PREINC: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(control_mode_select && req_x.valid && req_x.op == IPAG_OP_PRE_INC) |=>
		res_x.illegal)
		else $error("control mode pre increment accepted");

	AST_LINEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(req_x.valid && req_x.op == IPAG_OP_PLAIN &&
		!pointer_config_status[req_x.ptr_sel]) |=>
		res_x.addr == $past(extended_auxiliary_pointer[req_x.ptr_sel]))
		else $error("linear address not the pointer");

	AST_DSP_SHORT: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!control_mode_select && req_x.valid && req_x.op == IPAG_OP_SHORT_OFS) |=>
		res_x.illegal)
		else $error("dsp mode short offset accepted");
endmodule : ipag_core
`default_nettype wire

//--- ipag_ptr_model.sv
// Far-side pointer file: holds the pointers and takes result write-backs
`default_nettype none
module ipag_ptr_model
	import ipag_pkg::*;
(
	input  wire logic                           sys_clk, // CPU clock
	input  wire logic                           rst_b,   // Sync reset
	input  wire ipag_res_type                   res_x,   // First result
	input  wire ipag_res_type                   res_y,   // Second result
	output var  logic [NUM_PTR-1:0][ADDR_W-1:0] ptrs     // Pointer file
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			// Two below a page end, so small steps carry into the high part
			for (int i = 0; i < NUM_PTR; i++)
				ptrs[i] <= (ADDR_W'(i) << 16) | 23'h00fffe;
		end else begin
			if (res_x.ptr_we)
				ptrs[res_x.ptr_sel] <= res_x.ptr_new;
			// Second operand last: the core never lets both write one pointer
			if (res_y.ptr_we)
				ptrs[res_y.ptr_sel] <= res_y.ptr_new;
		end
	end
endmodule : ipag_ptr_model
`default_nettype wire

//--- indirect_pointer_address_gen_test.sv
// Self-checking bench for the indirect pointer address generator
`default_nettype none
module indirect_pointer_address_gen_test;
	import ipag_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic                           sys_clk, rst_b, dual_mode, ctrl, compat;
	ipag_req_type                   rx, ry;
	ipag_res_type                   res_x, res_y;
	logic [NUM_PTR-1:0][ADDR_W-1:0] ptrs;
	logic [WORD_W-1:0]              tmp1, tmp2, cfg;
	logic [3:0][WORD_W-1:0]         bsa;
	logic [ADDR_W-1:0]              ep;
	int                             err_count, checks_done, cyc;

	ipag_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .dual_mode(dual_mode),
		.req_x(rx), .req_y(ry), .extended_auxiliary_pointer(ptrs),
		.first_temp_register(tmp1), .second_temp_register(tmp2),
		.control_mode_select(ctrl), .legacy_compat_bit(compat),
		.pointer_config_status(cfg), .circular_start(bsa),
		.res_x(res_x), .res_y(res_y));
	ipag_ptr_model far (.sys_clk(sys_clk), .rst_b(rst_b), .res_x(res_x),
		.res_y(res_y), .ptrs(ptrs));

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Hang guard: the sequence needs about 100 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 2000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function automatic ipag_req_type mk(ipag_op_type op, ipag_acc_type acc,
		logic [2:0] sel);
		return '{1'h1, op, acc, sel, 16'h0010, 3'h7};
	endfunction : mk

	task automatic setm(input logic c, k);
		@(posedge sys_clk);
		ctrl <= c;
		compat <= k;
	endtask : setm

	// One request; results stand just after the edge that registers it
	task automatic go(input ipag_req_type x, y, input logic dm);
		@(posedge sys_clk);
		rx <= x;
		ry <= y;
		dual_mode <= dm;
		@(posedge sys_clk);
		rx <= '0;
		ry <= '0;
		dual_mode <= 1'h0;
		#1;
	endtask : go

	task automatic sx(input ipag_op_type op, input ipag_acc_type acc,
		input logic ill, input logic [ADDR_W-1:0] a, input logic we,
		input logic [ADDR_W-1:0] pn);
		go(mk(op, acc, 3'h2), '0, 1'h0);
		chk("illegal", res_x.illegal, ill);
		chk("valid", res_x.valid, !ill);
		chk("ptr_we", res_x.ptr_we, we);
		chk("y_valid", res_y.valid, 1'h0);
		if (!ill)
			chk("addr", res_x.addr, a);
		if (we) begin
			chk("ptr_new", res_x.ptr_new, pn);
			ep = pn;
		end
		@(posedge sys_clk);
		#1;
		chk("ptr2", ptrs[2], ep);
	endtask : sx

	// Pointer 2 linear, pointer 5 circular with its pair start
	task automatic dx(input logic c, input ipag_acc_type ax, ay);
		setm(c, 1'h0);
		go(mk(IPAG_OP_POST_INC, ax, 3'h2), mk(IPAG_OP_PLAIN, ay, 3'h5), 1'h1);
		chk("x_addr", res_x.addr, ep);
		chk("x_new", res_x.ptr_new, ep + 23'h1);
		chk("y_addr", res_y.addr, 23'h0600fe);
		chk("y_valid", res_y.valid, 1'h1);
		chk("y_we", res_y.ptr_we, 1'h0);
		ep = ep + 23'h1;
		go(mk(IPAG_OP_LONG_OFS, ax, 3'h2), mk(IPAG_OP_PLAIN, IPAG_ACC_MMR, 3'h5),
			1'h1);
		chk("x_ill", res_x.illegal, 1'h1);
		chk("y_ill", res_y.illegal, 1'h1);
		chk("y_we", res_y.ptr_we, 1'h0);
		// Same pointer on both sides, only the second one modifies it
		go(mk(IPAG_OP_PLAIN, ax, 3'h2), mk(IPAG_OP_POST_DEC, ay, 3'h2), 1'h1);
		chk("x_plain", res_x.addr, ep);
		chk("x_we", res_x.ptr_we, 1'h0);
		chk("y_addr2", res_y.addr, ep);
		chk("y_sel", res_y.ptr_sel, 3'h2);
		chk("y_we2", res_y.ptr_we, 1'h1);
		chk("y_new", res_y.ptr_new, ep - 23'h1);
		ep = ep - 23'h1;
	endtask : dx

	initial begin
		rst_b = 1'h0;
		dual_mode = 1'h0;
		ctrl = 1'h1;
		compat = 1'h0;
		rx = '0;
		ry = '0;
		tmp1 = 16'hfffe;
		tmp2 = 16'h0003;
		cfg = 16'h0020;
		bsa = {16'h0000, 16'h0100, 16'h0000, 16'h0000};
		err_count = 0;
		checks_done = 0;
		cyc = 0;
		ep = 23'h02fffe;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'h1;
		sx(IPAG_OP_SHORT_OFS, IPAG_ACC_SINGLE, 0, 23'h030005, 0, 23'h0);
		sx(IPAG_OP_POST_INC, IPAG_ACC_SINGLE, 0, ep, 1, 23'h02ffff);
		sx(IPAG_OP_POST_INC, IPAG_ACC_LONG, 0, ep, 1, 23'h030001);
		sx(IPAG_OP_POST_DEC, IPAG_ACC_LONG, 0, ep, 1, 23'h02ffff);
		sx(IPAG_OP_POST_DEC, IPAG_ACC_SINGLE, 0, ep, 1, 23'h02fffe);
		sx(IPAG_OP_REG_OFS, IPAG_ACC_SINGLE, 0, 23'h02fffc, 0, 23'h0);
		sx(IPAG_OP_POST_ADD_REG, IPAG_ACC_LONG, 0, ep, 1, 23'h02fffc);
		sx(IPAG_OP_POST_SUB_REG, IPAG_ACC_LONG, 0, ep, 1, 23'h02fffe);
		sx(IPAG_OP_POST_ADD_TMP2, IPAG_ACC_SINGLE, 0, ep, 1, 23'h030001);
		sx(IPAG_OP_POST_SUB_TMP2, IPAG_ACC_SINGLE, 0, ep, 1, 23'h02fffe);
		setm(1'h1, 1'h1);
		sx(IPAG_OP_POST_ADD_REG, IPAG_ACC_SINGLE, 0, ep, 1, 23'h03fffc);
		sx(IPAG_OP_REG_OFS, IPAG_ACC_SINGLE, 0, 23'h04fffa, 0, 23'h0);
		sx(IPAG_OP_POST_SUB_REG, IPAG_ACC_SINGLE, 0, ep, 1, 23'h02fffe);
		setm(1'h1, 1'h0);
		sx(IPAG_OP_PRE_INC, IPAG_ACC_SINGLE, 1, 23'h0, 0, 23'h0);
		sx(IPAG_OP_TMP2_OFS, IPAG_ACC_SINGLE, 1, 23'h0, 0, 23'h0);
		sx(IPAG_OP_LONG_OFS, IPAG_ACC_SINGLE, 0, 23'h03000e, 0, 23'h0);
		sx(IPAG_OP_PRE_ADD_LONG, IPAG_ACC_LONG, 0, 23'h03000e, 1,
			23'h03000e);
		setm(1'h0, 1'h0);
		sx(IPAG_OP_SHORT_OFS, IPAG_ACC_SINGLE, 1, 23'h0, 0, 23'h0);
		sx(IPAG_OP_PRE_DEC, IPAG_ACC_SINGLE, 0, 23'h03000d, 1, 23'h03000d);
		sx(IPAG_OP_PRE_INC, IPAG_ACC_SINGLE, 0, 23'h03000e, 1, 23'h03000e);
		sx(IPAG_OP_TMP2_OFS, IPAG_ACC_SINGLE, 0, 23'h030011, 0, 23'h0);
		// Reversed carry runs from the top bit down; subtract undoes it
		sx(IPAG_OP_POST_ADD_REV, IPAG_ACC_SINGLE, 0, ep, 1, 23'h7d000f);
		sx(IPAG_OP_POST_SUB_REV, IPAG_ACC_SINGLE, 0, ep, 1, 23'h03000e);
		dx(1'h1, IPAG_ACC_FIRST_DUAL, IPAG_ACC_SECOND_DUAL);
		dx(1'h0, IPAG_ACC_SINGLE, IPAG_ACC_SINGLE);
		complete_run();
	end
endmodule : indirect_pointer_address_gen_test
`default_nettype wire
